// ===== src/sbx_pkg.sv
// Package for the stack and branch execution unit.
// Assumes a 32-bit flat data path with one doubleword memory port.
package sbx_pkg;
	localparam int          DW          = 32;
	localparam int          SELW        = 16;
	localparam logic [31:0] DWORD_BYTES = 32'h0000_0004;
	localparam logic [31:0] SP_RESET    = 32'h0000_0000;
	localparam logic [31:0] IP_RESET    = 32'h0000_0000;
	localparam logic [15:0] CS_RESET    = 16'h0000;
	localparam logic [15:0] SS_RESET    = 16'h0000;
	localparam logic [2:0]  NUM_GPR     = 3'h7;
	localparam int          FLAGW       = 8;
	localparam logic [7:0]  FLAGS_RESET = 8'h02;

	typedef enum logic [4:0] {
		SBX_OP_NOP    = 5'h00,
		SBX_OP_PUSH   = 5'h01,
		SBX_OP_POP    = 5'h02,
		SBX_OP_PUSHA  = 5'h03,
		SBX_OP_POPA   = 5'h04,
		SBX_OP_ENTER  = 5'h05,
		SBX_OP_LEAVE  = 5'h06,
		SBX_OP_JMPN   = 5'h07,
		SBX_OP_JMPF   = 5'h08,
		SBX_OP_JCC    = 5'h09,
		SBX_OP_CALLN  = 5'h0a,
		SBX_OP_CALLF  = 5'h0b,
		SBX_OP_RETN   = 5'h0c,
		SBX_OP_RETF   = 5'h0d,
		SBX_OP_LOOP   = 5'h0e,
		SBX_OP_LOOPZ  = 5'h0f,
		SBX_OP_LOOPNZ = 5'h10,
		SBX_OP_JCXZ   = 5'h11,
		SBX_OP_BOUND  = 5'h12,
		SBX_OP_SETF   = 5'h13,
		SBX_OP_CLRF   = 5'h14,
		SBX_OP_LDSTAT = 5'h15,
		SBX_OP_STSTAT = 5'h16
	} sbx_op_t;

	typedef enum logic [2:0] {
		SBX_ST_IDLE  = 3'h0,
		SBX_ST_PUSH  = 3'h1,
		SBX_ST_POP   = 3'h2,
		SBX_ST_PUSH2 = 3'h3,
		SBX_ST_POP2  = 3'h4,
		SBX_ST_DONE  = 3'h5
	} sbx_state_t;
endpackage : sbx_pkg

// ===== src/sbx_gpr_if.sv
// Register-file access bundle between the unit and its general registers.
// Assumes one write and one read port, read data registered.
`timescale 1ns/1ps
interface sbx_gpr_if;
	logic        we;
	logic [2:0]  waddr;
	logic [31:0] wdata;
	logic [2:0]  raddr;
	logic [31:0] rdata;
	modport owner (output we, output waddr, output wdata, output raddr, input rdata);
	modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : sbx_gpr_if

// ===== src/sbx_gpr_file.sv
// Seven general registers (index 0..6) with a registered read port.
// Assumes reads are requested one cycle ahead of use.
`timescale 1ns/1ps
module sbx_gpr_file (
	// Clock and reset
	input  wire logic clk,
	input  wire logic arst_n,
	// Access
	sbx_gpr_if.store  port
);
	logic [31:0] mem_reg [0:6];
	logic [31:0] rdata_reg;

	genvar gi;
	generate
		for (gi = 0; gi < 7; gi++) begin : g_reg
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) mem_reg[gi] <= 32'h0000_0000;
				else if (port.we && port.waddr == 3'(gi)) mem_reg[gi] <= port.wdata;
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) rdata_reg <= 32'h0000_0000;
		else rdata_reg <= (port.raddr < sbx_pkg::NUM_GPR) ? mem_reg[port.raddr] : 32'h0000_0000;
	end
	assign port.rdata = rdata_reg;
endmodule : sbx_gpr_file

// ===== src/sbx_exec.sv
// Stack and branch execution unit for untyped instructions.
// Assumes memory answers a request with mem_ack and holds mem_rdata that cycle.
// How it works
// - Stack base is stack segment, top is stack pointer, a byte address moving by doublewords.
// - Push places one doubleword on top of the stack.
// - Pop removes top doubleword into a register or a memory location.
// - Push-all stores every general register; pop-all restores in reverse.
// - Enter builds a procedure frame with its display of frame links.
// - Leave removes display and frame, readying the return.
// - Near jump loads a 32-bit offset into instruction pointer, segment kept.
// - Far jump loads selector into code segment, offset into pointer.
// - Conditional jump branches only on required flag value, full reach.
// - Call pushes next address, then loads the target.
// - Far call saves old code segment and loads the new one too.
// - Return pops pointer, and code segment too when far.
// - Loop decrements count, falls through at zero, else branches.
// - Conditional loop also ends early when the chosen flag differs from op_fval.
// - Jump-if-count-zero branches when the count is zero.
// - Bound checks a subscript against lower and upper limits.
// - Set and clear flags; load and store the low status byte.
// - No-operation only advances the instruction pointer.
`timescale 1ns/1ps
module sbx_exec (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        arst_n,
	// Instruction issue
	input  wire logic        op_valid,
	output wire logic        op_ready,
	input  wire logic [4:0]  op_code,
	input  wire logic [31:0] op_imm,
	input  wire logic [15:0] op_sel,
	input  wire logic [31:0] op_data,
	input  wire logic [31:0] op_len,
	input  wire logic [2:0]  op_reg,
	input  wire logic        op_to_mem,
	input  wire logic [2:0]  op_flag,
	input  wire logic        op_fval,
	input  wire logic [4:0]  op_level,
	input  wire logic [31:0] op_lower,
	input  wire logic [31:0] op_upper,
	// Memory port
	output logic             mem_req,
	output logic             mem_we,
	output logic [15:0]      mem_seg,
	output logic [31:0]      mem_addr,
	output logic [31:0]      mem_wdata,
	input  wire logic        mem_ack,
	input  wire logic [31:0] mem_rdata,
	// Pop to memory result
	output logic             pop_valid,
	output logic [31:0]      pop_data,
	// Architectural state
	output logic [31:0]      stack_pointer_reg,
	output logic [31:0]      instr_pointer_reg,
	output logic [31:0]      loop_count_reg,
	output logic [15:0]      code_seg_reg,
	output logic [15:0]      stack_seg_reg,
	output logic [7:0]       flags_reg,
	output logic             bound_fault,
	output logic             op_done
);
	sbx_gpr_if gpr ();
	sbx_gpr_file u_gpr (.clk(clk), .arst_n(arst_n), .port(gpr));

	sbx_pkg::sbx_state_t state_reg;
	sbx_pkg::sbx_op_t    op_reg_q;
	logic [31:0] data_q, frame_q, next_ip_q;
	logic [15:0] sel_q;
	logic [2:0]  reg_q, idx_reg;
	logic        mem_q;
	logic [4:0]  lvl_reg;

	function automatic logic flag_is(input logic [7:0] f, input logic [2:0] n, input logic v);
		flag_is = (f[n] == v);
	endfunction : flag_is

	wire sbx_pkg::sbx_op_t op_in = sbx_pkg::sbx_op_t'(op_code);
	wire        take      = op_valid && op_ready;
	assign op_ready       = (state_reg == sbx_pkg::SBX_ST_IDLE);
	wire [31:0] seq_ip    = instr_pointer_reg + op_len;
	wire [31:0] cnt_dec   = loop_count_reg - 32'h0000_0001;
	wire        jcc_take  = flag_is(flags_reg, op_flag, op_fval);
	// Loop-zero and loop-not-zero both go on only while flag op_flag equals op_fval
	wire        loop_take = (cnt_dec != 32'h0000_0000) &&
	                        ((op_in == sbx_pkg::SBX_OP_LOOP) || jcc_take);
	wire [31:0] sp_dec    = stack_pointer_reg - sbx_pkg::DWORD_BYTES;
	wire [31:0] sp_inc    = stack_pointer_reg + sbx_pkg::DWORD_BYTES;
	wire        in_bound  = ($signed(op_data) >= $signed(op_lower)) &&
	                        ($signed(op_data) <= $signed(op_upper));
	wire        mem_fire  = mem_req && mem_ack;

	always_comb begin
		mem_req   = (state_reg == sbx_pkg::SBX_ST_PUSH) || (state_reg == sbx_pkg::SBX_ST_POP) ||
		            (state_reg == sbx_pkg::SBX_ST_PUSH2) || (state_reg == sbx_pkg::SBX_ST_POP2);
		mem_we    = (state_reg == sbx_pkg::SBX_ST_PUSH) || (state_reg == sbx_pkg::SBX_ST_PUSH2);
		mem_seg   = stack_seg_reg;
		mem_addr  = stack_pointer_reg;
		// Far call keeps the old segment in data_q for its first push
		mem_wdata = data_q;
		if (op_reg_q == sbx_pkg::SBX_OP_PUSHA) mem_wdata = gpr.rdata;
	end

	// Read one word ahead so a zero-wait memory still gets fresh push data
	assign gpr.raddr = op_ready ? 3'h0 : (mem_fire ? idx_reg + 3'h1 : idx_reg);

	// Pushes predecrement the pointer on entering a push state
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= sbx_pkg::SBX_ST_IDLE;
			op_reg_q  <= sbx_pkg::SBX_OP_NOP;
			data_q    <= 32'h0000_0000;
			frame_q   <= 32'h0000_0000;
			next_ip_q <= 32'h0000_0000;
			sel_q     <= 16'h0000;
			reg_q     <= 3'h0;
			idx_reg   <= 3'h0;
			mem_q     <= 1'b0;
			lvl_reg   <= 5'h00;
			stack_pointer_reg <= sbx_pkg::SP_RESET;
			instr_pointer_reg <= sbx_pkg::IP_RESET;
			loop_count_reg    <= 32'h0000_0000;
			code_seg_reg      <= sbx_pkg::CS_RESET;
			stack_seg_reg     <= sbx_pkg::SS_RESET;
			flags_reg         <= sbx_pkg::FLAGS_RESET;
			bound_fault       <= 1'b0;
			op_done           <= 1'b0;
			pop_valid         <= 1'b0;
			pop_data          <= 32'h0000_0000;
		end else begin
			op_done   <= 1'b0;
			pop_valid <= 1'b0;
			unique case (state_reg)
				sbx_pkg::SBX_ST_IDLE: if (take) begin
					op_reg_q  <= op_in;
					reg_q     <= op_reg;
					mem_q     <= op_to_mem;
					next_ip_q <= seq_ip;
					sel_q     <= code_seg_reg;
					lvl_reg   <= op_level;
					idx_reg   <= 3'h0;
					instr_pointer_reg <= seq_ip;
					op_done   <= 1'b1;
					unique case (op_in)
						sbx_pkg::SBX_OP_PUSH: begin
							data_q <= op_data;
							stack_pointer_reg <= sp_dec;
							state_reg <= sbx_pkg::SBX_ST_PUSH;
							op_done <= 1'b0;
						end
						sbx_pkg::SBX_OP_POP, sbx_pkg::SBX_OP_POPA, sbx_pkg::SBX_OP_RETN,
						sbx_pkg::SBX_OP_RETF: begin
							idx_reg <= (op_in == sbx_pkg::SBX_OP_POPA) ? 3'h6 : 3'h0;
							state_reg <= sbx_pkg::SBX_ST_POP;
							op_done <= 1'b0;
						end
						sbx_pkg::SBX_OP_PUSHA: begin
							stack_pointer_reg <= sp_dec;
							state_reg <= sbx_pkg::SBX_ST_PUSH;
							op_done <= 1'b0;
						end
						sbx_pkg::SBX_OP_ENTER: begin
							// Old frame pointer comes in on op_data
							data_q  <= op_data;
							frame_q <= sp_dec;
							stack_pointer_reg <= sp_dec;
							state_reg <= sbx_pkg::SBX_ST_PUSH;
							op_done <= 1'b0;
						end
						sbx_pkg::SBX_OP_LEAVE: begin
							// Pop the frame link at the frame pointer, then step past it
							stack_pointer_reg <= op_data;
							frame_q <= op_data;
							state_reg <= sbx_pkg::SBX_ST_POP2;
							op_done <= 1'b0;
						end
						sbx_pkg::SBX_OP_JMPN: instr_pointer_reg <= op_imm;
						sbx_pkg::SBX_OP_JMPF: begin
							instr_pointer_reg <= op_imm;
							code_seg_reg      <= op_sel;
						end
						sbx_pkg::SBX_OP_JCC: if (jcc_take) instr_pointer_reg <= op_imm;
						sbx_pkg::SBX_OP_CALLN, sbx_pkg::SBX_OP_CALLF: begin
							data_q <= seq_ip;
							frame_q <= op_imm;
							sel_q <= op_sel;
							stack_pointer_reg <= sp_dec;
							state_reg <= (op_in == sbx_pkg::SBX_OP_CALLF) ?
							             sbx_pkg::SBX_ST_PUSH2 : sbx_pkg::SBX_ST_PUSH;
							if (op_in == sbx_pkg::SBX_OP_CALLF) data_q <= {16'h0000, code_seg_reg};
							op_done <= 1'b0;
						end
						sbx_pkg::SBX_OP_LOOP, sbx_pkg::SBX_OP_LOOPZ, sbx_pkg::SBX_OP_LOOPNZ: begin
							loop_count_reg <= cnt_dec;
							if (loop_take) instr_pointer_reg <= op_imm;
						end
						sbx_pkg::SBX_OP_JCXZ:
							if (loop_count_reg == 32'h0000_0000) instr_pointer_reg <= op_imm;
						sbx_pkg::SBX_OP_BOUND: bound_fault <= !in_bound;
						sbx_pkg::SBX_OP_SETF: flags_reg[op_flag] <= 1'b1;
						sbx_pkg::SBX_OP_CLRF: flags_reg[op_flag] <= 1'b0;
						sbx_pkg::SBX_OP_LDSTAT: flags_reg <= op_data[7:0];
						sbx_pkg::SBX_OP_STSTAT: begin
							pop_data  <= {24'h000000, flags_reg};
							pop_valid <= 1'b1;
						end
						default: ;
					endcase
				end
				sbx_pkg::SBX_ST_PUSH: if (mem_fire) begin
					if (op_reg_q == sbx_pkg::SBX_OP_PUSHA && idx_reg != 3'h6) begin
						idx_reg <= idx_reg + 3'h1;
						stack_pointer_reg <= sp_dec;
					end else if (op_reg_q == sbx_pkg::SBX_OP_ENTER && lvl_reg != 5'h00) begin
						// Display: copy enclosing frame link, then the new one
						lvl_reg <= lvl_reg - 5'h01;
						data_q  <= (lvl_reg == 5'h01) ? frame_q : data_q - sbx_pkg::DWORD_BYTES;
						stack_pointer_reg <= sp_dec;
					end else begin
						if (op_reg_q == sbx_pkg::SBX_OP_CALLN ||
						    op_reg_q == sbx_pkg::SBX_OP_CALLF) begin
							instr_pointer_reg <= frame_q;
							if (op_reg_q == sbx_pkg::SBX_OP_CALLF) code_seg_reg <= sel_q;
						end
						if (op_reg_q == sbx_pkg::SBX_OP_ENTER) pop_data <= frame_q;
						pop_valid <= (op_reg_q == sbx_pkg::SBX_OP_ENTER);
						state_reg <= sbx_pkg::SBX_ST_DONE;
					end
				end
				sbx_pkg::SBX_ST_PUSH2: if (mem_fire) begin
					// Far call: old segment first, then return offset
					data_q <= next_ip_q;
					stack_pointer_reg <= sp_dec;
					state_reg <= sbx_pkg::SBX_ST_PUSH;
				end
				sbx_pkg::SBX_ST_POP, sbx_pkg::SBX_ST_POP2: if (mem_fire) begin
					stack_pointer_reg <= sp_inc;
					state_reg <= sbx_pkg::SBX_ST_DONE;
					unique case (op_reg_q)
						sbx_pkg::SBX_OP_POP: begin
							pop_data  <= mem_rdata;
							pop_valid <= mem_q;
						end
						sbx_pkg::SBX_OP_POPA: if (idx_reg != 3'h0) begin
							idx_reg   <= idx_reg - 3'h1;
							state_reg <= sbx_pkg::SBX_ST_POP;
						end
						sbx_pkg::SBX_OP_RETN: instr_pointer_reg <= mem_rdata;
						sbx_pkg::SBX_OP_RETF: if (state_reg == sbx_pkg::SBX_ST_POP) begin
							instr_pointer_reg <= mem_rdata;
							state_reg <= sbx_pkg::SBX_ST_POP2;
						end else begin
							code_seg_reg <= mem_rdata[15:0];
						end
						sbx_pkg::SBX_OP_LEAVE: begin
							pop_data  <= mem_rdata;
							pop_valid <= 1'b1;
						end
						default: ;
					endcase
				end
				sbx_pkg::SBX_ST_DONE: begin
					op_done   <= 1'b1;
					state_reg <= sbx_pkg::SBX_ST_IDLE;
				end
				default: state_reg <= sbx_pkg::SBX_ST_IDLE;
			endcase
		end
	end

	// Register writes for pop and pop-all; pop-all skips nothing, the pointer copy included
	assign gpr.we    = (state_reg == sbx_pkg::SBX_ST_POP) && mem_fire && !mem_q &&
	                   (op_reg_q == sbx_pkg::SBX_OP_POP || op_reg_q == sbx_pkg::SBX_OP_POPA);
	assign gpr.waddr = (op_reg_q == sbx_pkg::SBX_OP_POPA) ? idx_reg : reg_q;
	assign gpr.wdata = mem_rdata;

	chk_push_predec: assert property (@(posedge clk) disable iff (!arst_n)
		take && op_in == sbx_pkg::SBX_OP_PUSH |=> stack_pointer_reg == $past(sp_dec))
		else $error("push did not predecrement stack pointer");
	chk_jmp_near: assert property (@(posedge clk) disable iff (!arst_n)
		take && op_in == sbx_pkg::SBX_OP_JMPN |=> instr_pointer_reg == $past(op_imm)
		&& $stable(code_seg_reg))
		else $error("near jump target wrong");
	chk_jmp_far: assert property (@(posedge clk) disable iff (!arst_n)
		take && op_in == sbx_pkg::SBX_OP_JMPF |=> code_seg_reg == $past(op_sel))
		else $error("far jump selector not loaded");
	chk_jcc_hold: assert property (@(posedge clk) disable iff (!arst_n)
		take && op_in == sbx_pkg::SBX_OP_JCC && !jcc_take |=>
		instr_pointer_reg == $past(seq_ip))
		else $error("untaken jump moved elsewhere");
	chk_loop_count: assert property (@(posedge clk) disable iff (!arst_n)
		take && op_in == sbx_pkg::SBX_OP_LOOP |=> loop_count_reg == $past(cnt_dec))
		else $error("loop count not decremented");
	chk_jcxz_take: assert property (@(posedge clk) disable iff (!arst_n)
		take && op_in == sbx_pkg::SBX_OP_JCXZ && loop_count_reg == 32'h0000_0000 |=>
		instr_pointer_reg == $past(op_imm))
		else $error("zero count jump not taken");
	chk_bound_flag: assert property (@(posedge clk) disable iff (!arst_n)
		take && op_in == sbx_pkg::SBX_OP_BOUND |=> bound_fault == !$past(in_bound))
		else $error("bound result wrong");
	chk_nop_state: assert property (@(posedge clk) disable iff (!arst_n)
		take && op_in == sbx_pkg::SBX_OP_NOP |=> $stable(stack_pointer_reg)
		&& $stable(flags_reg) && op_done)
		else $error("nop changed state");
	chk_pop_postinc: assert property (@(posedge clk) disable iff (!arst_n)
		state_reg == sbx_pkg::SBX_ST_POP && mem_fire |=>
		stack_pointer_reg == $past(sp_inc))
		else $error("pop did not add four");
	chk_stack_seg: assert property (@(posedge clk) disable iff (!arst_n)
		mem_req |-> mem_seg == stack_seg_reg && mem_addr == stack_pointer_reg)
		else $error("stack access outside stack");
	cov_call_far: cover property (@(posedge clk) disable iff (!arst_n)
		take && op_in == sbx_pkg::SBX_OP_CALLF);
	cov_ret_far: cover property (@(posedge clk) disable iff (!arst_n)
		state_reg == sbx_pkg::SBX_ST_POP2 && mem_fire);
	cov_pusha: cover property (@(posedge clk) disable iff (!arst_n)
		take && op_in == sbx_pkg::SBX_OP_PUSHA);
endmodule : sbx_exec

// ===== test/tb_top.sv
// Self-checking bench for the stack and branch execution unit.
// Assumes the bench stands in for memory, acking each request after slow cycles.
`timescale 1ns/1ps
module tb_top;
	logic        clk, arst_n, op_valid, op_to_mem, op_fval;
	logic        mem_ack = 1'b0;
	logic [4:0]  op_code, op_level;
	logic [31:0] op_imm, op_data, op_len, op_lower, op_upper;
	logic [31:0] mem_rdata = 32'h0000_0000, pop_cap = 32'h0000_0000;
	logic [15:0] op_sel;
	logic [2:0]  op_reg, op_flag;
	wire         op_ready, mem_req, mem_we, pop_valid, bound_fault, op_done;
	wire  [15:0] mem_seg, code_seg_reg, stack_seg_reg;
	wire  [31:0] mem_addr, mem_wdata, pop_data, stack_pointer_reg;
	wire  [31:0] instr_pointer_reg, loop_count_reg;
	wire  [7:0]  flags_reg;
	int          n_errors, checks, lat, slow;
	logic [31:0] mem [logic [31:0]];
	logic [63:0] wq [$];

	sbx_exec u_sbx_exec (
		.clk(clk), .arst_n(arst_n), .op_valid(op_valid), .op_ready(op_ready),
		.op_code(op_code), .op_imm(op_imm), .op_sel(op_sel), .op_data(op_data),
		.op_len(op_len), .op_reg(op_reg), .op_to_mem(op_to_mem), .op_flag(op_flag),
		.op_fval(op_fval), .op_level(op_level), .op_lower(op_lower), .op_upper(op_upper),
		.mem_req(mem_req), .mem_we(mem_we), .mem_seg(mem_seg), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
		.pop_valid(pop_valid), .pop_data(pop_data),
		.stack_pointer_reg(stack_pointer_reg), .instr_pointer_reg(instr_pointer_reg),
		.loop_count_reg(loop_count_reg), .code_seg_reg(code_seg_reg),
		.stack_seg_reg(stack_seg_reg), .flags_reg(flags_reg),
		.bound_fault(bound_fault), .op_done(op_done));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Memory stand-in; a write lands at the edge where the design sees mem_ack
	// Released read data is inverted so stale values never match
	always @(posedge clk) begin
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (pop_valid === 1'b1)
			pop_cap <= pop_data;
		if (mem_ack === 1'b1 && mem_req === 1'b1 && mem_we === 1'b1) begin
			mem[mem_addr] = mem_wdata;
			wq.push_back({mem_addr, mem_wdata});
			chk({16'h0000, mem_seg}, {16'h0000, sbx_pkg::SS_RESET});
		end
		if (mem_req === 1'b1 && mem_ack !== 1'b1) begin
			if (lat < slow)
				lat <= lat + 1;
			else begin
				lat <= 0;
				mem_ack <= 1'b1;
				if (mem_we !== 1'b1)
					mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : ~mem_addr;
			end
		end
	end

	task automatic stop_test();
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : stop_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wchk(input int k, input logic [31:0] a, input logic [31:0] d);
		if (wq.size() <= k)
			chk(32'h0000_0000, 32'h0000_0001);
		else begin
			chk(wq[k][63:32], a);
			chk(wq[k][31:0], d);
		end
	endtask : wchk

	// One instruction; waits for op_done, then one more edge so pop_cap settles
	task automatic issue(input logic [4:0] c, input logic [31:0] im = 0, d = 0, ln = 0,
		input logic [15:0] sl = 0, input logic [2:0] rg = 0, fg = 0,
		input logic tm = 0, fv = 0, input logic [4:0] lv = 0);
		int i;
		@(posedge clk);
		op_valid <= 1'b1;
		op_code <= c;
		op_imm <= im;
		op_data <= d;
		op_len <= ln;
		op_sel <= sl;
		op_reg <= rg;
		op_flag <= fg;
		op_to_mem <= tm;
		op_fval <= fv;
		op_level <= lv;
		@(posedge clk);
		op_valid <= 1'b0;
		i = 0;
		#1;
		while (op_done !== 1'b1 && i < 300) begin
			@(posedge clk);
			#1;
			i++;
		end
		if (i == 300) begin
			n_errors++;
			$display("mismatch at %0t: op_done timeout", $time);
			stop_test();
		end
		@(posedge clk);
		#1;
	endtask : issue

	task automatic t_reset();
		chk(stack_pointer_reg, 32'h0000_0000);
		chk({16'h0000, stack_seg_reg}, 32'h0000_0000);
		chk(instr_pointer_reg, 32'h0000_0000);
		chk({24'h000000, flags_reg}, 32'h0000_0002);
		chk({31'h0, op_ready}, 32'h0000_0001);
	endtask : t_reset

	task automatic t_push_pop();
		slow = 3;
		wq.delete();
		issue(sbx_pkg::SBX_OP_PUSH, .d(32'h1234_5678));
		chk(stack_pointer_reg, 32'hffff_fffc);
		wchk(0, 32'hffff_fffc, 32'h1234_5678);
		issue(sbx_pkg::SBX_OP_POP, .tm(1'b1));
		chk(pop_cap, 32'h1234_5678);
		chk(stack_pointer_reg, 32'h0000_0000);
		slow = 0;
	endtask : t_push_pop

	task automatic t_jumps();
		issue(sbx_pkg::SBX_OP_JMPN, .im(32'h0000_0100));
		chk(instr_pointer_reg, 32'h0000_0100);
		chk({16'h0000, code_seg_reg}, 32'h0000_0000);
		issue(sbx_pkg::SBX_OP_JMPF, .im(32'h0000_0200), .sl(16'h0abc));
		chk({16'h0000, code_seg_reg}, 32'h0000_0abc);
		chk(instr_pointer_reg, 32'h0000_0200);
		issue(sbx_pkg::SBX_OP_NOP, .ln(32'h0000_0003));
		chk(instr_pointer_reg, 32'h0000_0203);
		chk(stack_pointer_reg, 32'h0000_0000);
		chk({24'h000000, flags_reg}, 32'h0000_0002);
		issue(sbx_pkg::SBX_OP_JCC, .im(32'h0000_0400), .ln(32'h2), .fg(3'h1), .fv(1'b1));
		chk(instr_pointer_reg, 32'h0000_0400);
		issue(sbx_pkg::SBX_OP_JCC, .im(32'h0000_0800), .ln(32'h2), .fg(3'h1), .fv(1'b0));
		chk(instr_pointer_reg, 32'h0000_0402);
	endtask : t_jumps

	task automatic t_calls();
		wq.delete();
		issue(sbx_pkg::SBX_OP_CALLN, .im(32'h0000_1000), .ln(32'h5));
		wchk(0, 32'hffff_fffc, 32'h0000_0407);
		chk(instr_pointer_reg, 32'h0000_1000);
		issue(sbx_pkg::SBX_OP_RETN);
		chk(instr_pointer_reg, 32'h0000_0407);
		chk(stack_pointer_reg, 32'h0000_0000);
		issue(sbx_pkg::SBX_OP_CALLF, .im(32'h0000_2000), .ln(32'h7), .sl(16'h0123));
		wchk(1, 32'hffff_fffc, 32'h0000_0abc);
		wchk(2, 32'hffff_fff8, 32'h0000_040e);
		chk({16'h0000, code_seg_reg}, 32'h0000_0123);
		chk(instr_pointer_reg, 32'h0000_2000);
		issue(sbx_pkg::SBX_OP_RETF);
		chk(instr_pointer_reg, 32'h0000_040e);
		chk({16'h0000, code_seg_reg}, 32'h0000_0abc);
		chk(stack_pointer_reg, 32'h0000_0000);
	endtask : t_calls

	task automatic t_loops();
		issue(sbx_pkg::SBX_OP_JCXZ, .im(32'h0000_3000), .ln(32'h2));
		chk(instr_pointer_reg, 32'h0000_3000);
		issue(sbx_pkg::SBX_OP_LOOP, .im(32'h0000_3100), .ln(32'h2));
		chk(loop_count_reg, 32'hffff_ffff);
		chk(instr_pointer_reg, 32'h0000_3100);
		issue(sbx_pkg::SBX_OP_JCXZ, .im(32'h0000_5000), .ln(32'h2));
		chk(instr_pointer_reg, 32'h0000_3102);
		issue(sbx_pkg::SBX_OP_LOOPZ, .im(32'h0000_6000), .ln(32'h2), .fg(3'h1), .fv(1'b0));
		chk(loop_count_reg, 32'hffff_fffe);
		chk(instr_pointer_reg, 32'h0000_3104);
		issue(sbx_pkg::SBX_OP_LOOPNZ, .im(32'h0000_7000), .ln(32'h2), .fg(3'h1), .fv(1'b1));
		chk(instr_pointer_reg, 32'h0000_7000);
	endtask : t_loops

	task automatic t_bound();
		logic [31:0] idx [5] = '{32'd10, 32'd20, 32'd15, 32'd21, 32'hffff_ffff};
		logic        flt [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
		@(posedge clk);
		op_lower <= 32'd10;
		op_upper <= 32'd20;
		for (int k = 0; k < 5; k++) begin
			issue(sbx_pkg::SBX_OP_BOUND, .d(idx[k]));
			chk({31'h0, bound_fault}, {31'h0, flt[k]});
		end
	endtask : t_bound

	task automatic t_flags();
		issue(sbx_pkg::SBX_OP_SETF, .fg(3'h6));
		chk({24'h000000, flags_reg}, 32'h0000_0042);
		issue(sbx_pkg::SBX_OP_CLRF, .fg(3'h6));
		chk({24'h000000, flags_reg}, 32'h0000_0002);
		issue(sbx_pkg::SBX_OP_LDSTAT, .d(32'h0000_00c7));
		chk({24'h000000, flags_reg}, 32'h0000_00c7);
		issue(sbx_pkg::SBX_OP_STSTAT);
		chk({24'h000000, pop_cap[7:0]}, 32'h0000_00c7);
	endtask : t_flags

	task automatic t_stack_all();
		issue(sbx_pkg::SBX_OP_PUSH, .d(32'ha5a5_0003));
		issue(sbx_pkg::SBX_OP_POP, .rg(3'h3));
		wq.delete();
		issue(sbx_pkg::SBX_OP_PUSHA);
		for (int k = 0; k < 7; k++)
			chk(wq[k][63:32], 32'hffff_fffc - 32'(4 * k));
		wchk(3, 32'hffff_fff0, 32'ha5a5_0003);
		chk(stack_pointer_reg, 32'hffff_ffe4);
		mem[32'hffff_fff0] = 32'h5a5a_5a5a;
		issue(sbx_pkg::SBX_OP_POPA);
		chk(stack_pointer_reg, 32'h0000_0000);
		wq.delete();
		issue(sbx_pkg::SBX_OP_PUSHA);
		wchk(3, 32'hffff_fff0, 32'h5a5a_5a5a);
		issue(sbx_pkg::SBX_OP_POPA);
	endtask : t_stack_all

	task automatic t_frame();
		wq.delete();
		issue(sbx_pkg::SBX_OP_ENTER, .d(32'h7777_0000), .lv(5'h01));
		wchk(0, 32'hffff_fffc, 32'h7777_0000);
		chk(pop_cap, 32'hffff_fffc);
		mem[32'h0000_8000] = 32'h1111_2222;
		issue(sbx_pkg::SBX_OP_LEAVE, .d(32'h0000_8000));
		chk(stack_pointer_reg, 32'h0000_8004);
		chk(pop_cap, 32'h1111_2222);
	endtask : t_frame

	initial begin
		{arst_n, op_valid, op_to_mem, op_fval} = '0;
		{op_code, op_level, op_imm, op_data, op_len, op_lower, op_upper} = '0;
		{op_sel, op_reg, op_flag} = '0;
		{n_errors, checks, slow} = '0;
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		#1;
		t_reset();
		t_push_pop();
		t_jumps();
		t_calls();
		t_loops();
		t_bound();
		t_stack_all();
		t_frame();
		t_flags();
		stop_test();
	end
endmodule : tb_top
